// >>> oids_core.sv
`timescale 1ns/10ps
`include "oids_regs.svh"
module oids_core #(
  parameter int unsigned FILT1 = `OIDS_DEB1_NS / (`OIDS_DEB_DIV * `OIDS_CLK_NS),
  parameter int unsigned FILT2 = `OIDS_DEB2_NS / (`OIDS_DEB_DIV * `OIDS_CLK_NS),
  parameter int unsigned FILT3 = `OIDS_DEB3_NS / (`OIDS_DEB_DIV * `OIDS_CLK_NS),
  parameter int unsigned SWH1  = `OIDS_SW1_NS / (2 * `OIDS_CLK_NS),
  parameter int unsigned SWH2  = `OIDS_SW2_NS / (2 * `OIDS_CLK_NS),
  parameter int unsigned SWH3  = `OIDS_SW3_NS / (2 * `OIDS_CLK_NS)
) (
  input  wire logic       core_clk_in,                    // 40 mhz core clock
  input  wire logic       rst_in,                         // sync reset, high
  input  wire logic [7:0] field_inputs_in,                // comparator levels
  input  wire logic       debounce_sel_lsb_in,            // debounce code bit 0
  input  wire logic       debounce_sel_msb_in,            // debounce code bit 1
  input  wire logic       width_select_in,                // 1 = 8-bit frame
  input  wire logic       chip_select_n_in,               // spi select, low
  input  wire logic       serial_clk_in,                  // spi clock
  input  wire logic       serial_chain_input_in,          // cascade data in
  input  wire logic       supply_below_off_in,            // supply under off level
  input  wire logic       supply_above_on_in,             // supply over on level
  input  wire logic       field_supply_absent_in,         // field supply open
  input  wire logic       temp_above_alarm_in,            // junction too hot
  output logic            serial_data_output_out,         // spi data level
  output logic            serial_data_output_oe_out,      // spi data drive
  output logic            supply_alarm_indication_out,    // open-drain level
  output logic            supply_alarm_indication_oe_out, // open-drain pull
  output logic            current_full_out                // 1 = full limit
);
  import oids_pkg::*;

  // ****************************************
  // parameter checks
  // ****************************************
  // a zero count would stall the timebase for that code
  if (FILT1 < 1 || FILT2 < 1 || FILT3 < 1 || SWH2 < 1 || SWH3 < 1) begin : g_chk
    $error("oids_core: timebase counts must be at least one");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [`OIDS_PIN_W-1:0] s1;
    logic [`OIDS_PIN_W-1:0] s2;
    logic                   cs_d;
    logic                   sclk_d;
    logic [7:0]             filt;
    logic [7:0]             prev;
    logic [7:0][1:0]        cnt;
    logic                   uv;
    logic                   ot;
    logic                   sdi_bit;
    logic                   w8;
    logic [15:0]            sr;
    logic                   sdo_en;
    logic                   fault;
  } oids_core_type;

  oids_core_type          r;
  oids_core_type          n;
  oids_frame_type         frame;
  oids_sel_type           sel;
  logic [`OIDS_PIN_W-1:0] raw;
  logic [7:0]             f_in;
  logic                   cs_n;
  logic                   sclk;
  logic                   sdi;
  logic                   wsel;
  logic                   below;
  logic                   above;
  logic                   absent;
  logic                   hot;
  logic                   cs_fall;
  logic                   sclk_rise;
  logic                   sclk_fall;
  logic                   tick;
  logic                   cur_full;

  oids_tb_if tbi ();

  // ****************************************
  // timebase
  // ****************************************
  // filter tick and current switching share one timebase
  oids_timebase #(
    .CNT_W (16),
    .FILT1 (FILT1),
    .FILT2 (FILT2),
    .FILT3 (FILT3),
    .SWH1  (SWH1),
    .SWH2  (SWH2),
    .SWH3  (SWH3)
  ) u_timebase (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .tb          (tbi.tb)
  );

  // select code and timebase outputs
  assign tbi.sel  = sel;
  assign tick     = tbi.tick;
  assign cur_full = tbi.cur_full;

  // ****************************************
  // pin gathering and decode
  // ****************************************
  // every outside pin into one vector for the synchroniser
  assign raw = {temp_above_alarm_in,
                field_supply_absent_in,
                supply_above_on_in,
                supply_below_off_in,
                debounce_sel_msb_in,
                debounce_sel_lsb_in,
                width_select_in,
                serial_chain_input_in,
                serial_clk_in,
                chip_select_n_in,
                field_inputs_in};

  // decode from second synchroniser stage only
  assign f_in   = r.s2[7:0];
  assign cs_n   = r.s2[`OIDS_P_CS];
  assign sclk   = r.s2[`OIDS_P_SCLK];
  assign sdi    = r.s2[`OIDS_P_SDI];
  assign wsel   = r.s2[`OIDS_P_WSEL];
  assign sel    = oids_sel_type'(r.s2[`OIDS_P_SEL_HI:`OIDS_P_SEL_LO]);
  assign below  = r.s2[`OIDS_P_BELOW];
  assign above  = r.s2[`OIDS_P_ABOVE];
  assign absent = r.s2[`OIDS_P_ABSENT];
  assign hot    = r.s2[`OIDS_P_HOT];

  // edges of the sampled link signals
  assign cs_fall   = r.cs_d & ~cs_n;
  assign sclk_rise = ~r.sclk_d & sclk;
  assign sclk_fall = r.sclk_d & ~sclk;

  // ****************************************
  // crc
  // ****************************************
  // serial crc over the inputs, msb first, from zero
  function automatic logic [4:0] oids_crc(input logic [7:0] d);
    logic [4:0] c;
    logic       fb;
    c = '0;
    for (int i = 7; i >= 0; i--) begin
      fb = c[4] ^ d[i];
      c  = {c[3:0], 1'b0};
      if (fb) begin
        c = c ^ `OIDS_CRC_POLY;
      end
    end
    return c;
  endfunction

  // ****************************************
  // frame assembly
  // ****************************************
  // channel eight leads, stop bit closes the frame
  always_comb begin
    frame.inputs = r.filt;
    frame.crc    = oids_crc(frame.inputs);
    frame.uv     = r.uv;
    frame.ot     = r.ot;
    frame.stop   = `OIDS_STOP_BIT;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n = r;

    // two-stage synchroniser for all pins
    n.s1     = raw;
    n.s2     = r.s1;
    n.cs_d   = cs_n;
    n.sclk_d = sclk;
    n.prev   = f_in;

    // glitch filter per channel
    for (int i = 0; i < `OIDS_CH_N; i++) begin
      if (sel == OIDS_DEB_OFF) begin
        n.filt[i] = f_in[i];
        n.cnt[i]  = 2'h0;
      end else if (f_in[i] == r.filt[i] || f_in[i] != r.prev[i]) begin
        n.cnt[i] = 2'h0;  // level moved or matches output, restart
      end else if (tick) begin
        if (r.cnt[i] == `OIDS_STABLE_TICKS - 2'h1) begin
          n.filt[i] = f_in[i];
          n.cnt[i]  = 2'h0;
        end else begin
          n.cnt[i] = r.cnt[i] + 2'h1;
        end
      end
    end

    // undervoltage with hysteresis, forced when supply absent
    if (absent || below) begin
      n.uv = 1'b1;
    end else if (above) begin
      n.uv = 1'b0;
    end

    // overtemperature follows the comparator
    n.ot = hot;

    // open-drain alarm on either condition
    n.fault = n.uv | n.ot;

    // spi data driven only while selected
    n.sdo_en = ~cs_n;

    // capture on select fall, shift while selected
    if (cs_fall) begin
      n.w8 = wsel;
      if (wsel == `OIDS_W8_SEL) begin
        n.sr = {frame.inputs, 8'h00};
      end else begin
        n.sr = frame;
      end
    end else if (!cs_n) begin
      if (sclk_rise) begin
        n.sdi_bit = sdi;  // chain input sampled on rising edge
      end
      if (sclk_fall) begin
        if (r.w8) begin
          n.sr[15:8] = {r.sr[14:8], r.sdi_bit};
        end else begin
          n.sr = {r.sr[14:0], r.sdi_bit};
        end
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************
  // select pins start released so no false capture follows reset
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      r                  <= '0;
      r.s1[`OIDS_P_CS]   <= 1'b1;
      r.s2[`OIDS_P_CS]   <= 1'b1;
      r.cs_d             <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // msb of the register is on the line from select onward
  assign serial_data_output_out         = r.sr[15];
  assign serial_data_output_oe_out      = r.sdo_en;
  // open-drain: level always low, enable pulls the line
  assign supply_alarm_indication_out    = 1'b0;
  assign supply_alarm_indication_oe_out = r.fault;
  // current limit level from the filter timebase
  assign current_full_out               = cur_full;

endmodule // oids_core

// >>> oids_core_monitor.sv
`timescale 1ns/10ps
module oids_core_monitor #(
  parameter int unsigned SWH1 = 160
) (
  input wire logic core_clk_in,                    // core clock
  input wire logic rst_in,                         // sync reset
  input wire logic debounce_sel_lsb_in,            // code bit 0
  input wire logic debounce_sel_msb_in,            // code bit 1
  input wire logic chip_select_n_in,               // select, low
  input wire logic serial_clk_in,                  // spi clock
  input wire logic supply_below_off_in,            // supply low
  input wire logic supply_above_on_in,             // supply good
  input wire logic field_supply_absent_in,         // supply open
  input wire logic temp_above_alarm_in,            // too hot
  input wire logic serial_data_output_out,         // data level
  input wire logic serial_data_output_oe_out,      // data drive
  input wire logic supply_alarm_indication_out,    // alarm level
  input wire logic supply_alarm_indication_oe_out, // alarm pull
  input wire logic current_full_out                // full limit
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // alarm line, flags and timebase relations
  a_alarm_level_low: assert property (supply_alarm_indication_out == 1'b0)
    else $error("alarm level not low");
  a_hot_alarm: assert property (temp_above_alarm_in [*5] |-> supply_alarm_indication_oe_out)
    else $error("alarm not raised on heat");
  a_absent_alarm: assert property (field_supply_absent_in [*5] |-> supply_alarm_indication_oe_out)
    else $error("alarm not raised on absent supply");
  a_alarm_release: assert property ((!temp_above_alarm_in && !supply_below_off_in && !field_supply_absent_in
    && supply_above_on_in) [*5] |-> !supply_alarm_indication_oe_out)
    else $error("alarm held after faults cleared");
  a_data_idle_off: assert property (chip_select_n_in [*6] |-> !serial_data_output_oe_out)
    else $error("data driven while idle");
  a_data_select_on: assert property (!chip_select_n_in [*6] |-> serial_data_output_oe_out)
    else $error("data not driven while selected");
  a_code0_full: assert property ((!debounce_sel_lsb_in && !debounce_sel_msb_in) [*6] |-> current_full_out)
    else $error("current reduced with switching off");
  a_current_toggles: assert property ((debounce_sel_lsb_in && !debounce_sel_msb_in) [*8]
    |-> ##[0:SWH1] $changed(current_full_out))
    else $error("current limit not toggling");
  a_bit_held_high: assert property ((!chip_select_n_in && serial_clk_in) [*3] |-> $stable(serial_data_output_out))
    else $error("data moved while clock high");
  c_frame: cover property (!chip_select_n_in && serial_clk_in);
  c_alarm: cover property ($rose(supply_alarm_indication_oe_out));
  c_low_current: cover property ($fell(current_full_out));
endmodule // oids_core_monitor
bind oids_core oids_core_monitor #(.SWH1(SWH1)) u_mon (.core_clk_in(core_clk_in), .rst_in(rst_in),
  .debounce_sel_lsb_in(debounce_sel_lsb_in), .debounce_sel_msb_in(debounce_sel_msb_in),
  .chip_select_n_in(chip_select_n_in), .serial_clk_in(serial_clk_in), .supply_below_off_in(supply_below_off_in),
  .supply_above_on_in(supply_above_on_in), .field_supply_absent_in(field_supply_absent_in),
  .temp_above_alarm_in(temp_above_alarm_in), .serial_data_output_out(serial_data_output_out),
  .serial_data_output_oe_out(serial_data_output_oe_out), .supply_alarm_indication_out(supply_alarm_indication_out),
  .supply_alarm_indication_oe_out(supply_alarm_indication_oe_out), .current_full_out(current_full_out));

// >>> oids_host_model.sv
`timescale 1ns/10ps
module oids_host_model (
  input  wire logic core_clk_in, // core clock
  input  wire logic sdo_in,      // device data level
  input  wire logic sdo_oe_in,   // device data drive
  output logic      cs_n_out,    // select, low
  output logic      sclk_out,    // serial clock
  output logic      chain_out    // upstream device data
);
  logic sdo_last_r;
  logic line;
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    chain_out = 1'b0;
    sdo_last_r = 1'b0;
  end
  // released line shows the inverse of its last driven level
  always @(posedge core_clk_in) if (sdo_oe_in) sdo_last_r <= sdo_in;
  assign line = sdo_oe_in ? sdo_in : ~sdo_last_r;
  // one 16-pulse frame, 200 ns clock only inside the frame
  task automatic frame(input logic [15:0] cv, output logic [15:0] got);
    int i;
    @(posedge core_clk_in);
    cs_n_out <= 1'b0;
    chain_out <= cv[15];
    repeat (8) @(posedge core_clk_in);
    for (i = 15; i >= 0; i--) begin
      sclk_out <= 1'b1;
      repeat (2) @(posedge core_clk_in);
      #1 got[i] = line;
      repeat (2) @(posedge core_clk_in);
      sclk_out <= 1'b0;
      chain_out <= (i > 0) ? cv[i-1] : 1'b0;
      repeat (4) @(posedge core_clk_in);
    end
    cs_n_out <= 1'b1;
    repeat (8) @(posedge core_clk_in);
  endtask
endmodule // oids_host_model

// >>> oids_pkg.sv
package oids_pkg;
  // debounce select codes in binary order
  typedef enum logic [1:0] {
    OIDS_DEB_OFF,
    OIDS_DEB_SHORT,
    OIDS_DEB_MID,
    OIDS_DEB_LONG
  } oids_sel_type;
  // 16-bit frame as it leaves msb first
  typedef struct packed {
    logic [7:0] inputs;
    logic [4:0] crc;
    logic       uv;
    logic       ot;
    logic       stop;
  } oids_frame_type;
endpackage : oids_pkg

// >>> oids_regs.svh
`ifndef OIDS_REGS_SVH
`define OIDS_REGS_SVH
// ****************************************
// timing figures, core clock and field
// ****************************************
`define OIDS_CLK_NS       25
`define OIDS_DEB1_NS      25000
`define OIDS_DEB2_NS      750000
`define OIDS_DEB3_NS      3000000
`define OIDS_DEB_DIV      3
`define OIDS_SW1_NS       8000
`define OIDS_SW2_NS       250000
`define OIDS_SW3_NS       1000000
`define OIDS_STABLE_TICKS 2'h3
// ****************************************
// frame layout and crc
// ****************************************
`define OIDS_CH_N         8
`define OIDS_FRAME_W      16
`define OIDS_CRC_W        5
`define OIDS_CRC_POLY     5'h15
`define OIDS_STOP_BIT     1'b1
`define OIDS_W8_SEL       1'b1
// ****************************************
// synchronised pin vector bit positions
// ****************************************
`define OIDS_PIN_W        18
`define OIDS_P_CS         8
`define OIDS_P_SCLK       9
`define OIDS_P_SDI        10
`define OIDS_P_WSEL       11
`define OIDS_P_SEL_LO     12
`define OIDS_P_SEL_HI     13
`define OIDS_P_BELOW      14
`define OIDS_P_ABOVE      15
`define OIDS_P_ABSENT     16
`define OIDS_P_HOT        17
`endif

// >>> oids_tb_if.sv
`timescale 1ns/10ps
interface oids_tb_if;
  import oids_pkg::*;
  oids_sel_type sel;
  logic         tick;
  logic         cur_full;
  modport core (output sel, input tick, input cur_full);
  modport tb (input sel, output tick, output cur_full);
endinterface : oids_tb_if

// >>> oids_timebase.sv
`timescale 1ns/10ps
module oids_timebase #(
  parameter int unsigned CNT_W = 16,
  parameter int unsigned FILT1 = 333,
  parameter int unsigned FILT2 = 10000,
  parameter int unsigned FILT3 = 40000,
  parameter int unsigned SWH1  = 160,
  parameter int unsigned SWH2  = 5000,
  parameter int unsigned SWH3  = 20000
) (
  input  wire logic core_clk_in,  // core clock
  input  wire logic rst_in,       // sync reset
  oids_tb_if.tb     tb            // select in, tick out
);
  import oids_pkg::*;
  typedef struct packed {
    oids_sel_type     sel_d;
    logic [CNT_W-1:0] fcnt;
    logic             tick;
    logic [CNT_W-1:0] ccnt;
    logic             cur_full;
  } oids_tbs_type;
  oids_tbs_type     r;
  oids_tbs_type     n;
  logic [CNT_W-1:0] flim;
  logic [CNT_W-1:0] clim;
  // counts that cannot reach the terminal value are refused
  if (FILT3 >= (2 ** CNT_W) || SWH3 >= (2 ** CNT_W) || FILT1 < 1 || SWH1 < 1) begin : g_chk
    $error("oids_timebase: counts do not fit the counter");
  end
  // filter tick every third of debounce time, switching half period
  always_comb begin
    n = r;
    n.sel_d = tb.sel;
    n.tick = 1'b0;
    unique case (tb.sel)
      OIDS_DEB_OFF:   begin flim = '0; clim = '0; end
      OIDS_DEB_SHORT: begin flim = CNT_W'(FILT1 - 1); clim = CNT_W'(SWH1 - 1); end
      OIDS_DEB_MID:   begin flim = CNT_W'(FILT2 - 1); clim = CNT_W'(SWH2 - 1); end
      OIDS_DEB_LONG:  begin flim = CNT_W'(FILT3 - 1); clim = CNT_W'(SWH3 - 1); end
    endcase
    if (tb.sel == OIDS_DEB_OFF || tb.sel != r.sel_d) begin
      n.fcnt = '0;
      n.ccnt = '0;
      n.cur_full = 1'b1;
    end else begin
      if (r.fcnt >= flim) begin
        n.fcnt = '0;
        n.tick = 1'b1;
      end else begin
        n.fcnt = r.fcnt + 1'b1;
      end
      if (r.ccnt >= clim) begin
        n.ccnt = '0;
        n.cur_full = ~r.cur_full;
      end else begin
        n.ccnt = r.ccnt + 1'b1;
      end
    end
  end
  // state register
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      r <= '0;
      r.cur_full <= 1'b1;
    end else begin
      r <= n;
    end
  end
  assign tb.tick = r.tick;
  assign tb.cur_full = r.cur_full;
endmodule // oids_timebase

// >>> tb_octal_input_debounce_serializer.sv
`timescale 1ns/10ps
module tb_octal_input_debounce_serializer;
  import oids_pkg::*;
  typedef struct packed {
    logic [7:0] fi;
    logic [1:0] code;
    logic       w, below, hot, euv, eot;
  } oids_row_type;
  localparam oids_row_type ROWS [6] = '{
    '{8'hA6, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0}, '{8'h3A, 2'h1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0},
    '{8'h81, 2'h2, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1}, '{8'hFF, 2'h3, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0},
    '{8'h4B, 2'h1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0}, '{8'h00, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0}};
  logic       clk, rst, w, lsb, msb, below, above, absent, hot, cs_n, sclk, chain;
  logic       sdo, sdo_oe, al, al_oe, cur;
  logic [7:0] fi;
  logic [15:0] got, exp;
  int         errors, checks_done, cyc;
  // ****************************************
  // clock, design and host
  // ****************************************
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  oids_core #(.FILT1(4), .FILT2(6), .FILT3(8), .SWH1(3), .SWH2(5)) uut (
    .core_clk_in(clk), .rst_in(rst), .field_inputs_in(fi), .debounce_sel_lsb_in(lsb), .debounce_sel_msb_in(msb),
    .width_select_in(w), .chip_select_n_in(cs_n), .serial_clk_in(sclk), .serial_chain_input_in(chain),
    .supply_below_off_in(below), .supply_above_on_in(above), .field_supply_absent_in(absent),
    .temp_above_alarm_in(hot), .serial_data_output_out(sdo), .serial_data_output_oe_out(sdo_oe),
    .supply_alarm_indication_out(al), .supply_alarm_indication_oe_out(al_oe), .current_full_out(cur));
  oids_host_model host (.core_clk_in(clk), .sdo_in(sdo), .sdo_oe_in(sdo_oe), .cs_n_out(cs_n), .sclk_out(sclk),
    .chain_out(chain));
  // ****************************************
  // compare, verdict and crc reference
  // ****************************************
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] expv);
    checks_done++;
    if (seen !== expv) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, expv, seen);
    end
  endtask
  task results;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [4:0] crc5(input logic [7:0] d);
    logic [4:0] c;
    c = 5'h00;
    for (int i = 7; i >= 0; i--) c = {c[3:0], 1'b0} ^ ((c[4] ^ d[i]) ? 5'h15 : 5'h00);
    return c;
  endfunction
  // current limit holds each level for a half period of the selected code
  task automatic half_period(input logic [1:0] code, input logic [15:0] half);
    logic [15:0] cnt;
    logic        lvl;
    @(posedge clk);
    {msb, lsb} <= code;
    repeat (10) @(posedge clk);
    #1 lvl = cur;
    while (cur == lvl) begin
      @(posedge clk);
      #1;
    end
    repeat (2) begin
      lvl = cur;
      cnt = 16'h0000;
      while (cur == lvl) begin
        @(posedge clk);
        #1 cnt++;
      end
      check("half period", cnt, half);
    end
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {rst, fi, lsb, msb, w, below, absent, hot} = {1'b1, 8'h00, 6'h00};
    above = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check("data drive", sdo_oe, 1'b0);
    check("alarm pull", al_oe, 1'b0);
    check("current", cur, 1'b1);
    check("alarm level", al, 1'b0);
    foreach (ROWS[r]) begin
      @(posedge clk);
      fi <= ROWS[r].fi;
      {msb, lsb} <= ROWS[r].code;
      w <= ROWS[r].w;
      below <= ROWS[r].below;
      above <= !ROWS[r].below;
      hot <= ROWS[r].hot;
      repeat (60) @(posedge clk);
      host.frame(16'hA5C3, got);
      exp = ROWS[r].w ? {ROWS[r].fi, 8'hA5} : {ROWS[r].fi, crc5(ROWS[r].fi), ROWS[r].euv, ROWS[r].eot, 1'b1};
      check("frame", got, exp);
      check("alarm pull", al_oe, ROWS[r].euv | ROWS[r].eot);
      check("data drive", sdo_oe, 1'b0);
    end
    // short pulse rejected, then a steady level passes
    lsb <= 1'b1;
    repeat (30) @(posedge clk);
    fi <= 8'hFF;
    repeat (6) @(posedge clk);
    fi <= 8'h00;
    repeat (30) @(posedge clk);
    host.frame(16'h0000, got);
    check("glitch", got[15:8], 8'h00);
    fi <= 8'hC1;
    repeat (30) @(posedge clk);
    host.frame(16'h0000, got);
    check("settled", got[15:8], 8'hC1);
    // current switching half periods for two codes
    half_period(2'h1, 16'h0003);
    half_period(2'h2, 16'h0005);
    // undervoltage holds until the supply is above the on level
    above <= 1'b0;
    below <= 1'b1;
    repeat (10) @(posedge clk);
    below <= 1'b0;
    repeat (10) @(posedge clk);
    check("uv held", al_oe, 1'b1);
    above <= 1'b1;
    repeat (10) @(posedge clk);
    check("uv cleared", al_oe, 1'b0);
    // absent field supply forces undervoltage
    absent <= 1'b1;
    repeat (20) @(posedge clk);
    host.frame(16'h0000, got);
    check("absent uv", {got[2], al_oe}, 2'h3);
    // reset in mid-run clears the alarm, absent supply raises it again
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check("reset pull", al_oe, 1'b0);
    check("reset current", cur, 1'b1);
    @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    #1 check("absent again", al_oe, 1'b1);
    results();
  end
endmodule // tb_octal_input_debounce_serializer
